// File: rtl/sar_adc_control.sv
// Control logic of a five-input 8-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_control
    import sar_adc_pkg::*;
#(
    parameter int RES_W = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    // Register port
    input  wire logic [7:0]       addr_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [7:0]       rdata_out,
    // Analog front end and pins
    input  wire logic             cmp_in,
    input  wire logic             rc_clk_in,
    input  wire logic             sleep_in,
    output logic      [RES_W-1:0] dac_code_out,
    output logic      [2:0]       channel_out,
    output logic                  channel_valid_out,
    output logic                  sample_switch_out,
    output logic                  converter_power_out,
    output logic      [4:0]       pin_analog_out,
    output logic                  ref_from_pin_out,
    // Interrupt
    output logic                  irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        clk_sel_t    clk_sel;
        logic [2:0]  channel;
        logic        go;
        logic        rsvd;
        logic        on;
        logic [2:0]  pin_fn;
        logic [7:0]  result;
        logic        flag;
        logic        irq_en;
        logic        irq;
        logic [7:0]  rdata;
        conv_state_t st;
        logic [2:0]  recov;
        logic        cmp_s1;
        logic        cmp_s2;
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
        logic        slp_s1;
        logic        slp_s2;
        logic        sample;
        logic        ch_valid;
        logic [4:0]  analog;
        logic        ref_pin;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    sar_if #(.RES_W(RES_W)) sar ();

    logic half_tick;
    logic tick_run;
    logic wr_ctrl;
    logic new_go;
    logic new_on;

    if (RES_W != 8) begin : g_chk
        $error("sar_adc_control serves an 8-bit result only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator stops in sleep, so only the RC source keeps ticking then
    assign tick_run = (s_q.st == ST_CONV || s_q.st == ST_RECOV)
                      && (!s_q.slp_s2 || s_q.clk_sel == CLK_RC);

    tad_tick_gen u_tick (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .run_in        (tick_run),
        .sel_in        (s_q.clk_sel),
        .rc_edge_in    (s_q.rc_s2 ^ s_q.rc_s3),
        .half_tick_out (half_tick)
    );

    sar_engine #(.RES_W(RES_W)) u_engine (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .sar        (sar)
    );

    assign wr_ctrl = wr_in && addr_in == `CTRL_OFFSET;
    assign new_go  = wdata_in[`GO_BIT];
    assign new_on  = wdata_in[`ON_BIT];

    assign sar.start = wr_ctrl && new_go && s_q.on && new_on
                       && s_q.st == ST_ACQ;
    assign sar.abort = s_q.st == ST_CONV && wr_ctrl && (!new_go || !new_on);
    assign sar.step  = half_tick && s_q.st == ST_CONV;
    assign sar.cmp   = s_q.cmp_s2;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.cmp_s1 = cmp_in;
        s_d.cmp_s2 = s_q.cmp_s1;
        s_d.rc_s1  = rc_clk_in;
        s_d.rc_s2  = s_q.rc_s1;
        s_d.rc_s3  = s_q.rc_s2;
        s_d.slp_s1 = sleep_in;
        s_d.slp_s2 = s_q.slp_s1;

        // Register writes
        if (wr_ctrl) begin
            s_d.clk_sel = clk_sel_t'(wdata_in[`CLK_SEL_LSB +: 2]);
            s_d.channel = wdata_in[`CH_SEL_LSB +: 3];
            s_d.rsvd    = wdata_in[`RSVD_BIT];
            s_d.on      = new_on;
        end else if (wr_in && addr_in == `CFG_OFFSET) begin
            s_d.pin_fn = wdata_in[2:0];
        end else if (wr_in && addr_in == `RESULT_OFFSET) begin
            s_d.result = wdata_in;
        end else if (wr_in && addr_in == `IRQ_CLR_OFFSET) begin
            if (wdata_in[0]) begin
                s_d.flag = 1'b0;
            end
        end else if (wr_in && addr_in == `IRQ_EN_OFFSET) begin
            s_d.irq_en = wdata_in[0];
        end

        // Conversion sequence
        case (s_q.st)
            ST_OFF: begin
                if (s_d.on) begin
                    s_d.st = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (!s_d.on) begin
                    s_d.st = ST_OFF;
                end else if (sar.start) begin
                    s_d.st = ST_CONV;
                    s_d.go = 1'b1;
                end
            end
            ST_CONV: begin
                if (sar.abort) begin
                    s_d.go = 1'b0;
                    s_d.st = s_d.on ? ST_RECOV : ST_OFF;
                    s_d.recov = 3'h0;
                end else if (sar.done) begin
                    s_d.go = 1'b0;
                    s_d.result = sar.result;
                    s_d.flag = 1'b1;
                    s_d.st = ST_RECOV;
                    s_d.recov = 3'h0;
                end
            end
            ST_RECOV: begin
                if (!s_d.on) begin
                    s_d.st = ST_OFF;
                end else if (half_tick) begin
                    s_d.recov = s_q.recov + 3'h1;
                    if (s_q.recov + 3'h1 >= `HALVES_RECOV) begin
                        s_d.st = ST_ACQ;
                    end
                end
            end
            default: begin
                s_d.st = ST_OFF;
            end
        endcase

        // Go never reads one outside a conversion
        if (s_d.st != ST_CONV) begin
            s_d.go = 1'b0;
        end

        s_d.ch_valid = s_d.channel <= 3'h4;
        s_d.sample   = s_d.st == ST_ACQ && s_d.ch_valid;

        case (s_d.pin_fn)
            3'h0, 3'h2: begin
                s_d.analog  = 5'h1f;
                s_d.ref_pin = 1'b0;
            end
            3'h1, 3'h3: begin
                s_d.analog  = 5'h17;
                s_d.ref_pin = 1'b1;
            end
            3'h4: begin
                s_d.analog  = 5'h0b;
                s_d.ref_pin = 1'b0;
            end
            default: begin
                // Reserved codes fall back to all digital, the safe pin state
                s_d.analog  = 5'h00;
                s_d.ref_pin = 1'b0;
            end
        endcase

        s_d.irq = s_d.flag && s_d.irq_en;

        // Read data stand in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd_in) begin
            if (addr_in == `CTRL_OFFSET) begin
                s_d.rdata = {s_q.clk_sel, s_q.channel, s_q.go, s_q.rsvd, s_q.on};
            end else if (addr_in == `CFG_OFFSET) begin
                s_d.rdata = {5'h00, s_q.pin_fn};
            end else if (addr_in == `RESULT_OFFSET) begin
                s_d.rdata = s_q.result;
            end else if (addr_in == `IRQ_STAT_OFFSET) begin
                s_d.rdata = {7'h00, s_q.flag};
            end else if (addr_in == `IRQ_EN_OFFSET) begin
                s_d.rdata = {7'h00, s_q.irq_en};
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        // Completion wins over a clear in the same cycle
        if (s_q.st == ST_CONV && sar.done && !sar.abort) begin
            s_d.flag = 1'b1;
            s_d.irq  = s_q.irq_en || (wr_in && addr_in == `IRQ_EN_OFFSET && wdata_in[0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q        <= '0;
            s_q.analog <= 5'h1f;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out           = s_q.rdata;
    assign dac_code_out        = sar.trial;
    assign channel_out         = s_q.channel;
    assign channel_valid_out   = s_q.ch_valid;
    assign sample_switch_out   = s_q.sample;
    assign converter_power_out = s_q.on;
    assign pin_analog_out      = s_q.analog;
    assign ref_from_pin_out    = s_q.ref_pin;
    assign irq_out             = s_q.irq;
endmodule
`default_nettype wire

// File: rtl/sar_adc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
`define CTRL_OFFSET      8'h1f
`define CFG_OFFSET       8'h9f
`define RESULT_OFFSET    8'h1e
`define IRQ_STAT_OFFSET  8'h20
`define IRQ_CLR_OFFSET   8'h21
`define IRQ_EN_OFFSET    8'h22
`define CLK_SEL_LSB      6
`define CH_SEL_LSB       3
`define GO_BIT           2
`define RSVD_BIT         1
`define ON_BIT           0
`define CTRL_RESET       8'h00
`define CFG_RESET        3'h0
`define HALVES_SETUP     5'd3
`define HALVES_RECOV     3'd4
`define HALF_DIV2        5'd1
`define HALF_DIV8        5'd4
`define HALF_DIV32       5'd16
`endif

// File: rtl/sar_adc_pkg.sv
// Types shared by the converter control modules
package sar_adc_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_CONV, ST_RECOV} conv_state_t;
    typedef enum logic [1:0] {CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC} clk_sel_t;
endpackage

// File: rtl/sar_if.sv
// Handshake between the control logic and the approximation engine
`timescale 1ns/100ps
`default_nettype none
interface sar_if #(parameter int RES_W = 8);
    logic             start;
    logic             abort;
    logic             step;
    logic             cmp;
    logic             done;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;
    modport ctrl   (output start, abort, step, cmp, input done, trial, result);
    modport engine (input start, abort, step, cmp, output done, trial, result);
endinterface
`default_nettype wire

// File: rtl/tad_tick_gen.sv
// Half bit-period tick generator from the oscillator or the private RC clock
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_map.svh"
module tad_tick_gen
    import sar_adc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Control
    input  wire logic       run_in,
    input  wire clk_sel_t   sel_in,
    input  wire logic       rc_edge_in,
    // Tick
    output logic            half_tick_out
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;
    logic [4:0]  half_len;

    always_comb begin
        case (sel_in)
            CLK_DIV2:  half_len = `HALF_DIV2;
            CLK_DIV8:  half_len = `HALF_DIV8;
            CLK_DIV32: half_len = `HALF_DIV32;
            default:   half_len = `HALF_DIV2;
        endcase
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run_in) begin
            s_d.cnt = 5'h00;
        end else if (sel_in == CLK_RC) begin
            s_d.cnt = 5'h00;
            s_d.tick = rc_edge_in;
        end else if (s_q.cnt + 5'h01 >= half_len) begin
            s_d.cnt = 5'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign half_tick_out = s_q.tick;
endmodule
`default_nettype wire

// File: rtl/sar_engine.sv
// Successive-approximation engine stepped in half bit periods
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_engine #(
    parameter int RES_W = 8
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    // Control side
    sar_if.engine     sar
);
    typedef struct packed {
        logic             busy;
        logic             done;
        logic [4:0]       cnt;
        logic [2:0]       idx;
        logic [RES_W-1:0] trial;
        logic [RES_W-1:0] result;
    } eng_state_t;

    eng_state_t s_q;
    eng_state_t s_d;
    logic [4:0] past_setup;

    if (RES_W != 8) begin : g_chk
        $error("sar_engine serves an 8-bit result only");
    end

    assign past_setup = s_q.cnt - `HALVES_SETUP;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (sar.abort) begin
            s_d.busy = 1'b0;
        end else if (sar.start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 5'h00;
            s_d.idx = 3'h7;
            s_d.trial = {1'b1, {(RES_W-1){1'b0}}};
        end else if (s_q.busy && sar.step) begin
            s_d.cnt = s_q.cnt + 5'h01;
            // Bit decided at the end of each whole bit period after setup
            if (s_q.cnt > `HALVES_SETUP && past_setup[0]) begin
                if (!sar.cmp) begin
                    s_d.trial[s_q.idx] = 1'b0;
                end
                if (s_q.idx == 3'h0) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.result = s_d.trial;
                end else begin
                    s_d.trial[s_q.idx - 3'h1] = 1'b1;
                    s_d.idx = s_q.idx - 3'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sar.done   = s_q.done;
    assign sar.trial  = s_q.trial;
    assign sar.result = s_q.result;
endmodule
`default_nettype wire

// File: test/sar_adc_control_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_control_chk (
    // Clock and reset
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Converter and pins
    input wire logic [2:0] channel_out,
    input wire logic       channel_valid_out,
    input wire logic       sample_switch_out,
    input wire logic       converter_power_out,
    input wire logic [4:0] pin_analog_out,
    input wire logic       ref_from_pin_out,
    input wire logic       irq_out
);
    logic [2:0] cfg_q;
    logic       en_q;
    logic [4:0] pin_exp;
    logic       vref_pin;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of written values, since the checker sees no registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= 3'h0;
            en_q  <= 1'b0;
        end else if (wr_in && addr_in == `CFG_OFFSET) begin
            cfg_q <= wdata_in[2:0];
        end else if (wr_in && addr_in == `IRQ_EN_OFFSET) begin
            en_q <= wdata_in[0];
        end
    end
    // Pin 3 is the reference for 001 and 011, so its analog bit is left open
    always_comb begin
        vref_pin = {cfg_q[2], cfg_q[0]} == 2'b01;
        case (cfg_q)
            3'h0, 3'h2: pin_exp = 5'h1f;
            3'h1, 3'h3: pin_exp = 5'h17;
            3'h4:       pin_exp = 5'h0b;
            default:    pin_exp = 5'h00;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_cfg_upper_zero: assert property (rd_in && addr_in == `CFG_OFFSET |=> rdata_out[7:3] == 5'h00)
        else $error("upper config bits read nonzero");
    a_power_follows: assert property (wr_in && addr_in == `CTRL_OFFSET |=> converter_power_out == $past(wdata_in[0]))
        else $error("power output differs from written on bit");
    a_power_off_open: assert property (!converter_power_out [*2] |-> !sample_switch_out)
        else $error("sample switch closed while converter off");
    a_chan_valid: assert property ($past(rst_n_in) |-> channel_valid_out == (channel_out <= 3'd4))
        else $error("channel valid flag wrong");
    a_reserved_open: assert property (channel_out > 3'd4 && $past(channel_out) > 3'd4 |-> !sample_switch_out)
        else $error("reserved channel connected");
    a_pin_map: assert property ($stable(cfg_q) |-> (pin_analog_out & (vref_pin ? 5'h17 : 5'h1f)) == pin_exp && ref_from_pin_out == vref_pin)
        else $error("pin function map wrong");
    a_irq_masked: assert property (!en_q && !$past(en_q) |-> !irq_out)
        else $error("interrupt high while disabled");
    a_clear_drops: assert property (wr_in && addr_in == `IRQ_CLR_OFFSET && wdata_in[0] |-> ##[1:2] !irq_out)
        else $error("interrupt stayed high after clear");
    a_recov_open: assert property ($rose(irq_out) && $past(en_q, 2) |-> !sample_switch_out [*2])
        else $error("sample switch closed right after completion");
    cover property (rd_in && addr_in == `CTRL_OFFSET);
    cover property ($rose(irq_out));
    cover property (channel_out > 3'd4 && converter_power_out);
    cover property ($fell(converter_power_out));
endmodule
bind sar_adc_control sar_adc_control_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .channel_out(channel_out),
    .channel_valid_out(channel_valid_out), .sample_switch_out(sample_switch_out),
    .converter_power_out(converter_power_out), .pin_analog_out(pin_analog_out),
    .ref_from_pin_out(ref_from_pin_out), .irq_out(irq_out)
);
`default_nettype wire

// File: test/sar_adc_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_map.svh"
module sar_adc_control_bench;
    logic       ref_clk_in, rst_n_in, wr_in, rd_in, cmp_in, rc_clk_in, sleep_in;
    logic [7:0] addr_in, wdata_in, rdata_out, dac_code_out, vin, rv;
    logic [4:0] pin_analog_out;
    logic [2:0] channel_out, ch;
    logic [1:0] sel;
    logic       channel_valid_out, sample_switch_out, converter_power_out;
    logic       ref_from_pin_out, irq_out, poll;
    int         errors, comparisons, n, h, t0, k;
    int         cyc = 0;
    sar_adc_control u_dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .cmp_in(cmp_in), .rc_clk_in(rc_clk_in), .sleep_in(sleep_in),
        .dac_code_out(dac_code_out), .channel_out(channel_out),
        .channel_valid_out(channel_valid_out), .sample_switch_out(sample_switch_out),
        .converter_power_out(converter_power_out), .pin_analog_out(pin_analog_out),
        .ref_from_pin_out(ref_from_pin_out), .irq_out(irq_out)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // Private RC oscillator runs free; an edge every 5 clocks is one half bit
    initial forever begin
        repeat (5) @(posedge ref_clk_in);
        rc_clk_in <= ~rc_clk_in;
    end
    // Input level sits half a step above vin, so the ideal result is vin
    always @(posedge ref_clk_in) begin
        cmp_in <= vin >= dac_code_out;
        cyc <= cyc + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        rd_in   <= 1'b0;
        @(negedge ref_clk_in);
        rv = rdata_out;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(s, e, rv);
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk_in);
        errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_in, wr_in, rd_in, cmp_in, rc_clk_in, sleep_in} = 6'h00;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        vin = 8'h00;
        errors = 0;
        comparisons = 0;
        void'($urandom(32'h639dfc44));
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rchk("control", `CTRL_OFFSET, `CTRL_RESET);
        rchk("config", `CFG_OFFSET, 8'h00);
        rchk("unmapped", 8'h55, 8'h00);
        chk("pins", 8'h1f, {3'h0, pin_analog_out});
        for (int c = 0; c < 8; c++) begin
            wr(`CFG_OFFSET, 8'hf8 | 8'(c));
            rchk("config", `CFG_OFFSET, 8'(c));
        end
        wr(`CFG_OFFSET, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(`CTRL_OFFSET, {2'b01, 3'(c), 3'b001});
            repeat (3) @(negedge ref_clk_in);
            chk("channel", 8'(c), {5'h0, channel_out});
            chk("sample", {7'h0, c < 5}, {7'h0, sample_switch_out});
        end
        wr(`CTRL_OFFSET, 8'h00);
        wr(`CTRL_OFFSET, 8'h44);
        rchk("go while off", `CTRL_OFFSET, 8'h40);
        chk("power", 8'h00, {7'h0, converter_power_out});
        for (n = 0; n < 8; n++) begin
            sel = (n < 4) ? 2'(n) : (n > 5) ? 2'b11 : 2'b01;
            h = sel == 2'b00 ? 1 : sel == 2'b01 ? 4 : sel == 2'b10 ? 16 : 5;
            vin = n == 0 ? 8'h00 : n == 1 ? 8'hff : 8'($urandom);
            ch = 3'($urandom % 5);
            poll = n[0];
            wr(`IRQ_EN_OFFSET, {7'h0, !poll});
            wr(`CTRL_OFFSET, {sel, ch, 3'b001});
            repeat (80) @(posedge ref_clk_in);
            sleep_in <= sel == 2'b11;
            wr(`CTRL_OFFSET, {sel, ch, 3'b101});
            t0 = cyc;
            rchk("go set", `CTRL_OFFSET, {sel, ch, 3'b101});
            k = 0;
            do begin
                if (poll) rd(`CTRL_OFFSET);
                else @(negedge ref_clk_in);
                k++;
            end while ((poll ? rv[2] : !irq_out) !== 1'b0 && k < 2000);
            chk("span ok", 8'h01, {7'h0, cyc - t0 >= 18 * h && cyc - t0 <= 20 * h + 8});
            chk("irq", {7'h0, !poll}, {7'h0, irq_out});
            rchk("go clear", `CTRL_OFFSET, {sel, ch, 3'b001});
            // Fosc/2 bit period is shorter than the comparator sync, so its code is not graded
            if (sel != 2'b00) rchk("result", `RESULT_OFFSET, vin);
            rchk("status", `IRQ_STAT_OFFSET, 8'h01);
            wr(`IRQ_EN_OFFSET, 8'h01);
            repeat (2) @(negedge ref_clk_in);
            chk("irq enabled", 8'h01, {7'h0, irq_out});
            wr(`IRQ_CLR_OFFSET, 8'h01);
            rchk("status", `IRQ_STAT_OFFSET, 8'h00);
            sleep_in <= 1'b0;
        end
        // Let the last recovery finish so the start below is taken
        repeat (40) @(posedge ref_clk_in);
        wr(`RESULT_OFFSET, 8'h5a);
        wr(`CTRL_OFFSET, 8'h45);
        rchk("abort go set", `CTRL_OFFSET, 8'h45);
        repeat (18) @(posedge ref_clk_in);
        wr(`CTRL_OFFSET, 8'h41);
        repeat (60) @(negedge ref_clk_in);
        rchk("kept result", `RESULT_OFFSET, 8'h5a);
        rchk("no flag", `IRQ_STAT_OFFSET, 8'h00);
        chk("reacquire", 8'h01, {7'h0, sample_switch_out});
        give_verdict();
    end
endmodule
`default_nettype wire
